// *** smc_core.v ***
// Serial master shift engine: control-word protocol writes and dual/quad writes
// Assumes an Avalon-MM master on the core clock and a slave on the serial pins
`timescale 1ns/100ps
`include "smc_map.vh"

module smc_core (
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  input  wire        i_clk_en,
  input  wire [5:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  input  wire [3:0]  i_rxd,
  output reg         o_sclk,
  output reg  [3:0]  o_txd,
  output reg  [3:0]  o_txd_oe,
  output reg         o_ss_n
);

  // ------------------------------------------------------------
  // States and phases
  // ------------------------------------------------------------
  localparam ST_IDLE  = 6'h01;
  localparam ST_SHIFT = 6'h02;
  localparam ST_BUSY  = 6'h04;
  localparam ST_READY = 6'h08;
  localparam ST_TAIL  = 6'h10;
  localparam ST_END   = 6'h20;

  localparam PH_CW    = 3'h0;
  localparam PH_DW    = 3'h1;
  localparam PH_INST  = 3'h2;
  localparam PH_ADDR  = 3'h3;
  localparam PH_DATA  = 3'h4;
  localparam PH_START = 3'h5;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [31:0] primary_control_reg;
  reg  [2:0]  ctrlword_protocol_control_reg;
  reg  [9:0]  multilane_control_reg;
  reg         enable;
  reg  [15:0] divider;
  reg         unsupported;

  reg  [31:0] fifo_mem [0:`SMC_FIFO_DEPTH-1];
  reg  [2:0]  wr_ptr;
  reg  [2:0]  rd_ptr;
  reg  [3:0]  fifo_count;

  reg  [3:0]  rx_s1;
  reg  [3:0]  rx_s2;
  reg  [3:0]  rx_s3;
  reg  [3:0]  rx_filt;

  reg  [5:0]  state;
  reg  [2:0]  phase;
  reg  [31:0] shreg;
  reg  [5:0]  bits_left;
  reg  [2:0]  lanes;
  reg  [3:0]  addr_left;
  reg  [15:0] half_cnt;
  reg         first_half;

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire [1:0]  frame_format_field      = primary_control_reg[`SMC_FRF_MSB:`SMC_FRF_LSB];
  wire [1:0]  lane_format_field       = primary_control_reg[`SMC_LFMT_MSB:`SMC_LFMT_LSB];
  wire [3:0]  control_word_length_field = primary_control_reg[`SMC_CFS_MSB:`SMC_CFS_LSB];
  wire [4:0]  wide_frame_size_field   = primary_control_reg[`SMC_DFS_MSB:`SMC_DFS_LSB];
  wire        sequential_transfer_bit = ctrlword_protocol_control_reg[`SMC_SEQ_BIT];
  wire        word_direction_bit      = ctrlword_protocol_control_reg[`SMC_DIR_BIT];
  // R4: handshake enable bit
  wire        handshake_enable_bit    = ctrlword_protocol_control_reg[`SMC_HS_BIT];
  wire [1:0]  phase_lane_type_field   = multilane_control_reg[`SMC_TT_MSB:`SMC_TT_LSB];
  wire [3:0]  addr_entries            = multilane_control_reg[`SMC_ADDRN_MSB:`SMC_ADDRN_LSB];
  wire [1:0]  instruction_length_field = multilane_control_reg[`SMC_INSTL_MSB:`SMC_INSTL_LSB];

  wire        is_cword   = (frame_format_field == `SMC_FRF_CWORD);
  // R19: lane format only in Motorola format
  wire        is_moto    = (frame_format_field == `SMC_FRF_MOTO);
  wire        is_multi   = is_moto && (lane_format_field != `SMC_LF_STD);
  wire        cpol       = is_moto & primary_control_reg[`SMC_CPOL_BIT];
  wire        cpha       = is_moto & primary_control_reg[`SMC_CPHA_BIT];

  // R12: dual or quad lanes only
  wire [2:0]  fmt_lanes  = !is_multi ? 3'h1 : (lane_format_field == `SMC_LF_DUAL) ? 3'h2 : 3'h4;
  // R18: phase type ignored in single-lane format
  wire [2:0]  inst_lanes = (phase_lane_type_field == `SMC_TT_ALL_WIDE) ? fmt_lanes : 3'h1;
  wire [2:0]  addr_lanes = (phase_lane_type_field != `SMC_TT_ALL_STD) ? fmt_lanes : 3'h1;
  // R22: control word 1 to 16 bits
  wire [5:0]  cw_len     = {2'h0, control_word_length_field} + 6'h01;
  wire [5:0]  dw_len     = {1'b0, wide_frame_size_field} + 6'h01;
  // R15: instruction 0, 4, 8 or 16 bits
  wire [5:0]  inst_len   = (instruction_length_field == 2'h0) ? 6'h00 :
                           (instruction_length_field == 2'h1) ? 6'h04 :
                           (instruction_length_field == 2'h2) ? 6'h08 : 6'h10;
  // R17: instruction and address written first
  wire [4:0]  need_cnt   = !is_multi ? 5'h01 : {1'b0, addr_entries} + ((inst_len != 6'h00) ? 5'h01 : 5'h00);
  wire        have_hdr   = ({1'b0, fifo_count} >= need_cnt) && (fifo_count != 4'h0);

  wire        fifo_empty = (fifo_count == 4'h0);
  wire        fifo_full  = (fifo_count == `SMC_FIFO_DEPTH);
  wire [31:0] fifo_head  = fifo_mem[rd_ptr];
  wire        half_tick  = (state != ST_IDLE) && (half_cnt == divider);
  wire        bit_end    = half_tick && !first_half;
  wire        last_bits  = (bits_left <= {3'h0, lanes});

  // R1: sequential write unsupported
  wire        seq_write  = is_cword && word_direction_bit && sequential_transfer_bit;
  wire        bad_mode   = seq_write || (is_moto && lane_format_field == `SMC_LF_OCTAL);

  wire        bus_req    = i_read || i_write;
  wire        data_wr    = i_write && (i_address == `SMC_OFF_DATA);
  wire        bus_take   = bus_req && !o_waitrequest;
  wire        push       = bus_take && data_wr;

  reg         pop;
  reg  [31:0] rd_mux;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [3:0] lane_out;
    input [31:0] word;
    input [2:0]  nl;
    begin
      case (nl)
        3'h4:    lane_out = word[31:28];
        3'h2:    lane_out = {2'h0, word[31:30]};
        default: lane_out = {3'h0, word[31]};
      endcase
    end
  endfunction

  function [3:0] lane_en;
    input [2:0] nl;
    begin
      case (nl)
        3'h4:    lane_en = 4'hF;
        3'h2:    lane_en = 4'h3;
        default: lane_en = 4'h1;
      endcase
    end
  endfunction

  function [31:0] align;
    input [31:0] word;
    input [5:0]  len;
    begin
      align = word << (`SMC_WORD_BITS - len);
    end
  endfunction

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always @* begin
    case (i_address)
      `SMC_OFF_PRIMARY: rd_mux = primary_control_reg;
      `SMC_OFF_PROTO:   rd_mux = {29'h0000_0000, ctrlword_protocol_control_reg};
      `SMC_OFF_MULTI:   rd_mux = {22'h00_0000, multilane_control_reg};
      `SMC_OFF_ENABLE:  rd_mux = {31'h0000_0000, enable};
      `SMC_OFF_DIVIDER: rd_mux = {16'h0000, divider};
      `SMC_OFF_STATUS:  rd_mux = {20'h0_0000, rx_filt, fifo_count, unsupported, fifo_full,
                                  fifo_empty, (state != ST_IDLE)};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // Avalon slave and configuration
  // ------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_waitrequest                 <= 1'b1;
      o_readdata                    <= 32'h0000_0000;
      primary_control_reg           <= `SMC_RST_PRIMARY;
      ctrlword_protocol_control_reg <= 3'h0;
      multilane_control_reg         <= 10'h000;
      enable                        <= 1'b0;
      divider                       <= `SMC_RST_DIVIDER;
    end else if (i_clk_en) begin
      if (bus_take || !bus_req) begin
        o_waitrequest <= 1'b1;
      end else if (!(data_wr && fifo_full)) begin
        o_waitrequest <= 1'b0;
        o_readdata    <= i_read ? rd_mux : 32'h0000_0000;
      end
      if (bus_take && i_write) begin
        case (i_address)
          `SMC_OFF_PRIMARY: primary_control_reg <= i_writedata;
          `SMC_OFF_PROTO:   ctrlword_protocol_control_reg <= i_writedata[2:0];
          `SMC_OFF_MULTI:   multilane_control_reg <= i_writedata[9:0];
          `SMC_OFF_ENABLE:  enable <= i_writedata[0];
          `SMC_OFF_DIVIDER: divider <= (i_writedata[15:0] == 16'h0000) ? 16'h0001 : i_writedata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit FIFO
  // ------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wr_ptr     <= 3'h0;
      rd_ptr     <= 3'h0;
      fifo_count <= 4'h0;
    end else if (i_clk_en) begin
      if (push) begin
        fifo_mem[wr_ptr] <= i_writedata;
        wr_ptr           <= wr_ptr + 3'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      fifo_count <= fifo_count + (push ? 4'h1 : 4'h0) - (pop ? 4'h1 : 4'h0);
    end
  end

  // ------------------------------------------------------------
  // Receive line synchroniser
  // ------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rx_s1   <= 4'h0;
      rx_s2   <= 4'h0;
      rx_s3   <= 4'h0;
      rx_filt <= 4'h0;
    end else if (i_clk_en) begin
      rx_s1 <= i_rxd;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_filt <= rx_s2;
      end
    end
  end

  // ------------------------------------------------------------
  // Shift sequencer
  // ------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state       <= ST_IDLE;
      phase       <= PH_CW;
      shreg       <= 32'h0000_0000;
      bits_left   <= 6'h00;
      lanes       <= 3'h1;
      addr_left   <= 4'h0;
      half_cnt    <= 16'h0001;
      first_half  <= 1'b1;
      unsupported <= 1'b0;
      pop         <= 1'b0;
      o_sclk      <= 1'b0;
      o_txd       <= 4'h0;
      o_txd_oe    <= 4'h0;
      o_ss_n      <= 1'b1;
    end else if (i_clk_en) begin
      pop <= 1'b0;
      // Serial clock divider
      if (state != ST_IDLE) begin
        if (half_tick) begin
          half_cnt   <= 16'h0001;
          first_half <= ~first_half;
          // R13: polarity and phase in Motorola format only, multi-lane included
          o_sclk     <= (state == ST_BUSY || state == ST_READY) ? o_sclk : cpol ^ cpha ^ first_half;
        end else begin
          half_cnt <= half_cnt + 16'h0001;
        end
      end
      if (bus_take && i_write && i_address == `SMC_OFF_STATUS && i_writedata[3]) begin
        unsupported <= 1'b0;
      end
      // R1: refuse sequential write
      if (state == ST_IDLE && enable && bad_mode) begin
        unsupported <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          o_sclk <= cpol;
          if (enable && !bad_mode && !pop && have_hdr) begin
            state      <= ST_SHIFT;
            half_cnt   <= 16'h0001;
            first_half <= 1'b1;
            o_sclk     <= cpol ^ cpha;
            o_ss_n     <= 1'b0;
            pop        <= 1'b1;
            addr_left  <= addr_entries;
            if (is_cword) begin
              // R8: first entry is the control word
              phase     <= PH_CW;
              shreg     <= align(fifo_head, cw_len);
              bits_left <= cw_len;
              lanes     <= 3'h1;
              o_txd     <= lane_out(align(fifo_head, cw_len), 3'h1);
              o_txd_oe  <= 4'h1;
            end else if (is_multi && inst_len != 6'h00) begin
              // R14: instruction phase first
              // R16: instruction is one entry
              phase     <= PH_INST;
              shreg     <= align(fifo_head, inst_len);
              bits_left <= inst_len;
              lanes     <= inst_lanes;
              o_txd     <= lane_out(align(fifo_head, inst_len), inst_lanes);
              o_txd_oe  <= lane_en(inst_lanes);
            end else if (is_multi && addr_entries != 4'h0) begin
              phase     <= PH_ADDR;
              addr_left <= addr_entries - 4'h1;
              shreg     <= align(fifo_head, dw_len);
              bits_left <= dw_len;
              lanes     <= addr_lanes;
              o_txd     <= lane_out(align(fifo_head, dw_len), addr_lanes);
              o_txd_oe  <= lane_en(addr_lanes);
            end else begin
              phase     <= PH_DATA;
              shreg     <= align(fifo_head, dw_len);
              bits_left <= dw_len;
              lanes     <= fmt_lanes;
              o_txd     <= lane_out(align(fifo_head, dw_len), fmt_lanes);
              o_txd_oe  <= lane_en(fmt_lanes);
            end
          end
        end
        ST_SHIFT: begin
          if (bit_end && !last_bits) begin
            shreg     <= shreg << lanes;
            bits_left <= bits_left - {3'h0, lanes};
            o_txd     <= lane_out(shreg << lanes, lanes);
          end else if (bit_end) begin
            case (phase)
              PH_CW: begin
                // R23: data follows control word LSB
                // R9: second entry taken as data
                if (word_direction_bit && !fifo_empty && !pop) begin
                  phase     <= PH_DW;
                  pop       <= 1'b1;
                  shreg     <= align(fifo_head, dw_len);
                  bits_left <= dw_len;
                  o_txd     <= lane_out(align(fifo_head, dw_len), 3'h1);
                end else if (handshake_enable_bit) begin
                  state <= ST_BUSY;
                  o_txd <= 4'h0;
                end else begin
                  // R11: one more serial cycle, then end
                  state <= ST_TAIL;
                  o_txd <= 4'h0;
                end
              end
              PH_DW: begin
                if (handshake_enable_bit) begin
                  // R5: wait for slave ready
                  state <= ST_BUSY;
                  o_txd <= 4'h0;
                end else if (!fifo_empty && !pop) begin
                  // R2: next control word without gap
                  // R3: further pairs continue transfer
                  phase     <= PH_CW;
                  pop       <= 1'b1;
                  shreg     <= align(fifo_head, cw_len);
                  bits_left <= cw_len;
                  o_txd     <= lane_out(align(fifo_head, cw_len), 3'h1);
                end else begin
                  state <= ST_END;
                end
              end
              PH_START: begin
                state <= ST_END;
              end
              default: begin
                if (phase != PH_DATA && addr_left != 4'h0 && !fifo_empty && !pop) begin
                  // R14: address after instruction
                  phase     <= PH_ADDR;
                  pop       <= 1'b1;
                  addr_left <= addr_left - 4'h1;
                  shreg     <= align(fifo_head, dw_len);
                  bits_left <= dw_len;
                  lanes     <= addr_lanes;
                  o_txd     <= lane_out(align(fifo_head, dw_len), addr_lanes);
                  o_txd_oe  <= lane_en(addr_lanes);
                end else if (!fifo_empty && !pop) begin
                  // R20: data until FIFO empty
                  phase     <= PH_DATA;
                  pop       <= 1'b1;
                  shreg     <= align(fifo_head, dw_len);
                  bits_left <= dw_len;
                  lanes     <= fmt_lanes;
                  o_txd     <= lane_out(align(fifo_head, dw_len), fmt_lanes);
                  o_txd_oe  <= lane_en(fmt_lanes);
                end else begin
                  state <= ST_END;
                end
              end
            endcase
          end
        end
        ST_BUSY: begin
          // R6: busy seen on receive line
          if (bit_end && !rx_filt[0]) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          if (bit_end && rx_filt[0]) begin
            state <= ST_SHIFT;
            if (!fifo_empty && !pop) begin
              // R5: next control word after ready
              phase     <= PH_CW;
              pop       <= 1'b1;
              shreg     <= align(fifo_head, cw_len);
              bits_left <= cw_len;
              o_txd     <= lane_out(align(fifo_head, cw_len), 3'h1);
            end else begin
              // R7: start bit clears ready
              phase     <= PH_START;
              shreg     <= 32'h8000_0000;
              bits_left <= 6'h01;
              o_txd     <= 4'h1;
            end
          end
        end
        ST_TAIL: begin
          if (bit_end) begin
            state <= ST_END;
          end
        end
        ST_END: begin
          state    <= ST_IDLE;
          o_ss_n   <= 1'b1;
          o_sclk   <= cpol;
          o_txd    <= 4'h0;
          o_txd_oe <= 4'h0;
          lanes    <= 3'h1;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** smc_map.vh ***
// Register map, field layout and constants of the serial master shift engine
// Assumes a 32-bit Avalon-MM master and a 125 MHz core clock
// Function
// R1: No sequential continuous control-word writes
// R2: Next control word follows data LSB directly
// R3: More FIFO pairs extend the transfer
// R4: Handshake enable is protocol control bit 2
// R5: Handshake waits for ready before continuing
// R6: Slave shows busy then ready on receive
// R7: Final start bit clears slave ready
// R8: Control-word-only transfer uses one FIFO entry
// R9: Second FIFO entry is always data; the code takes it as data only when the direction bit is one
// R10: Control-word-only needs direction bit one
// R11: No handshake: end one cycle after LSB
// R12: Dual and quad only, four-bit lanes
// R13: All clock polarity/phase modes in multi-lane
// R14: Instruction, address, then data phases
// R15: Instruction length 0, 4, 8 or 16
// R16: Instruction one entry, address several entries
// R17: Start only after instruction and address written
// R18: Single-lane format ignores phase lane type
// R19: Lane format only with frame format 00b
// R20: Data follows until transmit FIFO empty
// R21: Lane format 01 dual, 10 quad, 11 octal
// R22: Control word length 1 to 16 bits
// R23: Transmit data follows control word LSB
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SMC_OFF_PRIMARY   6'h00
`define SMC_OFF_PROTO     6'h04
`define SMC_OFF_MULTI     6'h08
`define SMC_OFF_ENABLE    6'h0C
`define SMC_OFF_DIVIDER   6'h10
`define SMC_OFF_STATUS    6'h14
`define SMC_OFF_DATA      6'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SMC_FRF_MSB       5
`define SMC_FRF_LSB       4
`define SMC_CPHA_BIT      6
`define SMC_CPOL_BIT      7
`define SMC_TRANSFER_DIRECTION_FIELD_MSB      9
`define SMC_TRANSFER_DIRECTION_FIELD_LSB      8
`define SMC_CFS_MSB       15
`define SMC_CFS_LSB       12
`define SMC_DFS_MSB       20
`define SMC_DFS_LSB       16
`define SMC_LFMT_MSB      22
`define SMC_LFMT_LSB      21
`define SMC_SEQ_BIT       0
`define SMC_DIR_BIT       1
`define SMC_HS_BIT        2
`define SMC_TT_MSB        1
`define SMC_TT_LSB        0
`define SMC_ADDRN_MSB     5
`define SMC_ADDRN_LSB     2
`define SMC_INSTL_MSB     9
`define SMC_INSTL_LSB     8

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define SMC_FRF_MOTO      2'h0
`define SMC_FRF_CWORD     2'h2
`define SMC_LF_STD        2'h0
`define SMC_LF_DUAL       2'h1
`define SMC_LF_QUAD       2'h2
`define SMC_LF_OCTAL      2'h3
`define SMC_TT_ALL_STD    2'h0
`define SMC_TT_ALL_WIDE   2'h2
`define SMC_RST_PRIMARY   32'h0007_0000
`define SMC_RST_DIVIDER   16'h0002
`define SMC_FIFO_DEPTH    8
`define SMC_FIFO_AW       3
`define SMC_WORD_BITS     6'h20

`endif

// *** smc_checker.sv ***
// Port assertions for the serial master shift engine
// Assumes a bind onto smc_core at the foot of this file
`timescale 1ns/100ps
module smc_checker (
  input wire       i_core_clk,
  input wire       i_sys_rst,
  input wire       i_read,
  input wire       i_write,
  input wire       o_waitrequest,
  input wire       o_sclk,
  input wire [3:0] o_txd_oe,
  input wire       o_ss_n
);
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rst_idle; disable iff (1'b0) i_sys_rst |=> o_ss_n && o_waitrequest && o_txd_oe == 4'h0; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset"); // Reset state
  property p_wait_pulse; !o_waitrequest |=> o_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long"); // Bus answer
  property p_wait_cause; $fell(o_waitrequest) |-> $past(i_read || i_write); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer unasked"); // Bus answer
  property p_oe_shape; o_txd_oe == 4'h0 || o_txd_oe == 4'h1 || o_txd_oe == 4'h3 || o_txd_oe == 4'hF; endproperty
  a_oe_shape: assert property (p_oe_shape) else $error("bad lane enable");
  property p_oe_idle; o_ss_n |-> o_txd_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven idle");
  property p_start_drive; $fell(o_ss_n) |-> o_txd_oe != 4'h0; endproperty
  a_start_drive: assert property (p_start_drive) else $error("first bit not driven");
  property p_frame_min; $fell(o_ss_n) |-> !o_ss_n [*3]; endproperty
  a_frame_min: assert property (p_frame_min) else $error("frame too short");
  property p_sclk_quiet; $changed(o_sclk) |-> !o_ss_n || !$past(o_ss_n) || !$past(o_waitrequest)
    || !$past(o_waitrequest, 2) || !$past(o_waitrequest, 3); endproperty
  a_sclk_quiet: assert property (p_sclk_quiet) else $error("sclk moved idle");
endmodule

bind smc_core smc_checker smc_checker_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_read(i_read),
  .i_write(i_write), .o_waitrequest(o_waitrequest), .o_sclk(o_sclk), .o_txd_oe(o_txd_oe), .o_ss_n(o_ss_n));

// *** smc_slave.sv ***
// Serial slave model: captures lanes, answers busy then ready
// Assumes sclk and txd registered on the same core clock
`timescale 1ns/100ps
module smc_slave (
  input  wire        i_clk,
  input  wire        i_sclk,
  input  wire [3:0]  i_txd,
  input  wire        i_ss_n,
  input  wire [1:0]  i_mode,
  input  wire [2:0]  i_lanes,
  input  wire [5:0]  i_hs_bits,
  input  wire [7:0]  i_busy,
  output reg  [3:0]  o_rxd,
  output reg  [63:0] o_bits,
  output reg  [6:0]  o_count,
  output reg  [7:0]  o_early
);
  reg       prev = 1'b0;
  reg       ss_d = 1'b1;
  reg [5:0] run = 6'h00;
  reg [7:0] bcnt = 8'h00;
  wire      cap = (i_sclk != prev) && (i_sclk == !(i_mode[1] ^ i_mode[0]));
  wire      hold = (i_hs_bits != 6'h00) && (run == i_hs_bits);
  initial o_rxd = 4'h5;
  always @(posedge i_clk) begin
    prev <= i_sclk;
    ss_d <= i_ss_n;
    bcnt <= (hold && bcnt != i_busy) ? bcnt + 8'h01 : bcnt;
    o_rxd <= hold ? {3'h0, bcnt == i_busy} : ~o_rxd;
    if (ss_d && !i_ss_n) begin
      o_bits <= 64'h0;
      o_count <= 7'h00;
      run <= 6'h00;
      o_early <= 8'h00;
    end else if (cap && !i_ss_n) begin
      o_bits <= (o_bits << i_lanes) | {60'h0, i_txd & ((4'h1 << i_lanes) - 4'h1)};
      o_count <= o_count + {4'h0, i_lanes};
      run <= hold ? 6'h01 : run + 6'h01;
      bcnt <= 8'h00;
      o_early <= (hold && bcnt != i_busy) ? o_early + 8'h01 : o_early;
    end
  end
endmodule

// *** test_serial_master_ctrlword_and_quad_write.sv ***
// Bench of the serial master shift engine
// Assumes smc_core, smc_slave and the bound checker
`timescale 1ns/100ps
`include "smc_map.vh"
module test_serial_master_ctrlword_and_quad_write;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [5:0]  adr = 6'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0000_0000;
  reg  [1:0]  mode = 2'h0;
  reg  [2:0]  ln = 3'h1;
  reg  [5:0]  hsb = 6'h00;
  reg  [9:0]  lc = 10'h000;
  reg         hi = 1'b1;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        wrq, sclk, ss_n;
  wire [3:0]  rxd, txd, oe;
  wire [63:0] bits;
  wire [6:0]  cnt;
  wire [7:0]  early;
  int         bad_count = 0;
  int         checked = 0;
  integer     m;
  smc_core smc_core_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_address(adr),
    .i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdat), .o_waitrequest(wrq),
    .i_rxd(rxd), .o_sclk(sclk), .o_txd(txd), .o_txd_oe(oe), .o_ss_n(ss_n));
  smc_slave smc_slave_inst (.i_clk(clk), .i_sclk(sclk), .i_txd(txd), .i_ss_n(ss_n), .i_mode(mode),
    .i_lanes(ln), .i_hs_bits(hsb), .i_busy(8'h0A), .o_rxd(rxd), .o_bits(bits), .o_count(cnt),
    .o_early(early));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    hi <= ss_n;
    if (!ss_n) lc <= hi ? 10'h001 : lc + 10'h001;
  end
  // -----
  // Tasks
  // -----
  task chk(input [63:0] s, input [63:0] e);
    checked = checked + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, s, e);
    end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wrq) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task push(input [31:0] d);
    bus(1'b1, `SMC_OFF_DATA, d);
  endtask
  task xfer(input [63:0] eb, input [6:0] ec, input [9:0] el);
    int n;
    for (n = 0; n < 400 && ss_n; n++) @(posedge clk);
    for (n = 0; n < 900 && !ss_n; n++) @(posedge clk);
    if (ec != 7'h00) chk(bits, eb);
    if (ec != 7'h00) chk(cnt, ec);
    if (el != 10'h000) chk(lc, el);
  endtask
  function [31:0] prim(input [1:0] f, input [1:0] cp, input [3:0] cw, input [4:0] fs, input [1:0] lf);
    prim = {9'h000, lf, fs, cw, 4'h1, cp, f, 4'h0};
  endfunction
  function [31:0] mlt(input [1:0] il, input [3:0] an);
    mlt = {22'h00_0000, il, 2'h0, an, `SMC_TT_ALL_WIDE};
  endfunction
  task summarize;
    $display("Checked %0d, bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #160000;
    bad_count = bad_count + 1;
    summarize;
  end
  // -----
  // Tests
  // -----
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `SMC_OFF_PRIMARY, 32'h0);
    chk(q, `SMC_RST_PRIMARY);
    bus(1'b0, `SMC_OFF_DIVIDER, 32'h0);
    chk(q, `SMC_RST_DIVIDER);
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
    bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_MOTO, 2'h0, 4'h0, 5'h07, `SMC_LF_QUAD));
    bus(1'b1, `SMC_OFF_MULTI, mlt(2'h2, 4'h1));
    ln <= 3'h4;
    push(32'hA5);
    repeat (30) @(posedge clk);
    chk(ss_n, 1'b1);
    push(32'h3C);
    xfer(64'hA53C, 7'd16, 10'd17);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h0);
    bus(1'b1, `SMC_OFF_MULTI, mlt(2'h3, 4'h2));
    push(32'hBEEF);
    push(32'h11);
    push(32'h22);
    push(32'h33);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
    xfer(64'hBE_EF11_2233, 7'd40, 10'd41);
    bus(1'b1, `SMC_OFF_MULTI, mlt(2'h0, 4'h1));
    ln <= 3'h2;
    for (m = 0; m < 4; m++) begin
      bus(1'b1, `SMC_OFF_ENABLE, 32'h0);
      bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_MOTO, m[1:0], 4'h0, 5'h07, `SMC_LF_DUAL));
      mode <= m[1:0];
      push(32'h5A);
      push(32'hC3);
      bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
      xfer(64'h5AC3, 7'd16, 10'd33);
    end
    mode <= 2'h0;
    ln <= 3'h1;
    bus(1'b1, `SMC_OFF_ENABLE, 32'h0);
    bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_MOTO, 2'h0, 4'h0, 5'h07, `SMC_LF_STD));
    bus(1'b1, `SMC_OFF_MULTI, mlt(2'h2, 4'h1));
    push(32'h9C);
    push(32'h81);
    push(32'h7E);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
    xfer(64'h9C_817E, 7'd24, 10'd97);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h0);
    bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_CWORD, 2'h0, 4'hF, 5'h07, `SMC_LF_QUAD));
    bus(1'b1, `SMC_OFF_PROTO, 32'h2);
    push(32'hABCD);
    push(32'hD2);
    push(32'h1234);
    push(32'hD4);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
    xfer(64'hABCD_D212_34D4, 7'd48, 10'd193);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h0);
    bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_CWORD, 2'h0, 4'h3, 5'h03, `SMC_LF_STD));
    bus(1'b1, `SMC_OFF_PROTO, 32'h6);
    hsb <= 6'd8;
    push(32'h9);
    push(32'h6);
    push(32'h5);
    push(32'hA);
    bus(1'b1, `SMC_OFF_ENABLE, 32'h1);
    xfer(64'h1_2CB5, 7'd17, 10'h000);
    chk(early, 8'h00);
    hsb <= 6'h00;
    bus(1'b1, `SMC_OFF_PRIMARY, prim(`SMC_FRF_CWORD, 2'h0, 4'h0, 5'h07, `SMC_LF_STD));
    bus(1'b1, `SMC_OFF_PROTO, 32'h3);
    push(32'h1);
    repeat (30) @(posedge clk);
    chk(ss_n, 1'b1);
    bus(1'b0, `SMC_OFF_STATUS, 32'h0);
    chk(q[3], 1'b1);
    bus(1'b1, `SMC_OFF_PROTO, 32'h2);
    xfer(64'h0, 7'h00, 10'd9);
    bus(1'b1, `SMC_OFF_STATUS, 32'h8);
    bus(1'b0, `SMC_OFF_STATUS, 32'h0);
    chk(q[3:0], 4'h2);
    summarize;
  end
endmodule
